// ### design/uit_params.svh
/*
 * Constants for the serial transceiver interrupt block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes it is included by bare name after the package is compiled.
 */
`ifndef UIT_PARAMS_SVH
`define UIT_PARAMS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define UIT_OFS_DATA        4'h0
`define UIT_OFS_CTRL        4'h4
`define UIT_OFS_FLAG        4'h8
`define UIT_OFS_LEVEL       4'hC
`define UIT_OFS_STATUS      5'h10
`define UIT_OFS_ENABLE      5'h14
`define UIT_OFS_CLEAR       5'h18
`define UIT_OFS_BAUD        5'h1C

// ************************************************************
// Field positions and reset values
// ************************************************************
`define UIT_CTRL_TXEN       0
`define UIT_CTRL_RXEN       1
`define UIT_CTRL_FIFOEN     2
`define UIT_CTRL_PAREN      3
`define UIT_CTRL_PARODD     4
`define UIT_IRQ_RX          0
`define UIT_IRQ_TX          1
`define UIT_IRQ_TO          2
`define UIT_IRQ_FE          3
`define UIT_IRQ_PE          4
`define UIT_IRQ_BE          5
`define UIT_IRQ_OE          6
`define UIT_FLAG_BUSY       0
`define UIT_FLAG_TXFULL     1
`define UIT_FLAG_RXEMPTY    2
`define UIT_CTRL_RST        5'h00
`define UIT_LEVEL_RST       3'h4
`define UIT_BAUD_RST        8'h1A

// ************************************************************
// Timing counts and FIFO depth
// ************************************************************
`define UIT_TIMEOUT_BITS    9'd511
`define UIT_OVS             4'hF
`define UIT_OVS_MID         4'h7
`define UIT_FIFO_DEPTH      4'h8

`endif

// ### design/uit_pkg.sv
/*
 * Types shared by the transceiver interrupt block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package uit_pkg;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} uit_tx_e;
   typedef logic [7:0] uit_byte_t;
endpackage : uit_pkg

// ### design/uit_rx.sv
/*
 * Receive frame engine: samples a synchronised serial line at 16x and
 * reports per-frame results as one-cycle pulses.
 * Assumes rxd_i already passed the three-stage synchroniser and that
 * tick_i is a one-cycle oversample strobe.
 */
`include "uit_params.svh"
module uit_rx (
   input  wire logic               core_clk_i,
   input  wire logic               sys_rst_i,
   input  wire logic               tick_i,
   input  wire logic               en_i,
   input  wire logic               par_en_i,
   input  wire logic               par_odd_i,
   input  wire logic               rxd_i,
   output logic                    done_o,
   output uit_pkg::uit_byte_t      data_o,
   output logic                    par_err_o,
   output logic                    frm_err_o,
   output logic                    brk_o
);
   // ************************************************************
   // Frame state
   // ************************************************************
   logic       busy, next_busy;
   logic [3:0] ovs, next_ovs;
   logic [3:0] bitn, next_bitn;
   logic [7:0] shr, next_shr;
   logic       par, next_par;
   logic       zero, next_zero;
   logic       next_done, next_pe, next_fe, next_brk;
   uit_pkg::uit_byte_t next_data;
   logic [3:0] last_bit;

   assign last_bit = par_en_i ? 4'hA : 4'h9;

   // Next state, sampling at mid-bit
   always_comb begin
      next_busy = busy;
      next_ovs  = ovs;
      next_bitn = bitn;
      next_shr  = shr;
      next_par  = par;
      next_zero = zero;
      next_done = 1'b0;
      next_pe   = 1'b0;
      next_fe   = 1'b0;
      next_brk  = 1'b0;
      next_data = data_o;
      if (!busy) begin
         if (en_i && tick_i && !rxd_i) begin
            next_busy = 1'b1;
            next_ovs  = 4'h0;
            next_bitn = 4'h0;
            next_par  = par_odd_i;
            next_zero = 1'b1;
         end
      end else if (tick_i) begin
         next_ovs = ovs + 4'h1;
         if (ovs == `UIT_OVS_MID) begin
            next_bitn = bitn + 4'h1;
            if (bitn == 4'h0 && rxd_i) begin
               next_busy = 1'b0;   // False start glitch
            end else if (bitn >= 4'h1 && bitn <= 4'h8) begin
               next_shr  = {rxd_i, shr[7:1]};
               next_par  = par ^ rxd_i;
               next_zero = zero & ~rxd_i;
            end else if (bitn == 4'h9 && par_en_i) begin
               next_pe   = (par ^ rxd_i);
               next_zero = zero & ~rxd_i;
            end
            if (bitn == last_bit) begin
               next_busy = 1'b0;
               next_done = 1'b1;
               next_data = shr;
               next_fe   = ~rxd_i;
               next_brk  = zero & ~rxd_i;
            end
         end
      end
   end

   // Registers
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         busy      <= 1'b0;
         ovs       <= 4'h0;
         bitn      <= 4'h0;
         shr       <= 8'h00;
         par       <= 1'b0;
         zero      <= 1'b0;
         done_o    <= 1'b0;
         data_o    <= 8'h00;
         par_err_o <= 1'b0;
         frm_err_o <= 1'b0;
         brk_o     <= 1'b0;
      end else begin
         busy      <= next_busy;
         ovs       <= next_ovs;
         bitn      <= next_bitn;
         shr       <= next_shr;
         par       <= next_par;
         zero      <= next_zero;
         done_o    <= next_done;
         data_o    <= next_data;
         par_err_o <= next_pe;
         frm_err_o <= next_fe;
         brk_o     <= next_brk;
      end
   end
endmodule : uit_rx

// ### design/uit_top.sv
/*
 * Serial transceiver with interrupt generation: transmit hold register and
 * shifter, receive FIFO, error and timeout events, sticky status, enable,
 * write-one clear and one level interrupt.
 * Assumes a single-cycle register port with read data one cycle later and
 * an asynchronous serial input from a remote device.
 */
// Implementation choices: the plain strobed port and the placing of the registers.
`include "uit_params.svh"
module uit_top (
   input  wire logic        core_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [4:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   input  wire logic        rxd_i,
   output logic             txd_o,
   output logic             irq_o
);
   // ************************************************************
   // Decoding
   // ************************************************************
   function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   logic wr_data, wr_ctrl, wr_level, wr_en, wr_clr, wr_baud, rd_data;
   assign wr_data  = wr_i && hit(addr_i, {1'b0, `UIT_OFS_DATA});
   assign wr_ctrl  = wr_i && hit(addr_i, {1'b0, `UIT_OFS_CTRL});
   assign wr_level = wr_i && hit(addr_i, {1'b0, `UIT_OFS_LEVEL});
   assign wr_en    = wr_i && hit(addr_i, `UIT_OFS_ENABLE);
   assign wr_clr   = wr_i && hit(addr_i, `UIT_OFS_CLEAR);
   assign wr_baud  = wr_i && hit(addr_i, `UIT_OFS_BAUD);
   assign rd_data  = rd_i && hit(addr_i, {1'b0, `UIT_OFS_DATA});

   // ************************************************************
   // Configuration registers
   // ************************************************************
   logic [4:0] ctrl, next_ctrl;
   logic [2:0] level, next_level;
   logic [6:0] irq_en, next_irq_en;
   logic [7:0] baud, next_baud;

   // Software-written settings
   always_comb begin
      next_ctrl   = wr_ctrl  ? wdata_i[4:0] : ctrl;
      next_level  = wr_level ? wdata_i[2:0] : level;
      next_irq_en = wr_en    ? wdata_i[6:0] : irq_en;
      next_baud   = wr_baud  ? wdata_i[7:0] : baud;
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl   <= `UIT_CTRL_RST;
         level  <= `UIT_LEVEL_RST;
         irq_en <= 7'h00;
         baud   <= `UIT_BAUD_RST;
      end else begin
         ctrl   <= next_ctrl;
         level  <= next_level;
         irq_en <= next_irq_en;
         baud   <= next_baud;
      end
   end

   // ************************************************************
   // Oversample clock and input synchroniser
   // ************************************************************
   logic [7:0] bdiv, next_bdiv;
   logic       tick;
   logic [2:0] rx_sync;
   logic       rx_line, next_rx_line;

   // Divider; a zero divisor still ticks every cycle rather than stalling
   always_comb begin
      tick      = (bdiv == 8'h00);
      next_bdiv = tick ? baud : bdiv - 8'h01;
      // Line level only moves when the last two stages agree
      next_rx_line = (rx_sync[2] == rx_sync[1]) ? rx_sync[1] : rx_line;
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bdiv    <= 8'h00;
         rx_sync <= 3'b111;
         rx_line <= 1'b1;
      end else begin
         bdiv    <= next_bdiv;
         rx_sync <= {rx_sync[1:0], rxd_i};
         rx_line <= next_rx_line;
      end
   end

   // ************************************************************
   // Transmitter
   // ************************************************************
   uit_pkg::uit_tx_e   tx_st, next_tx_st;
   uit_pkg::uit_byte_t hold, next_hold, tsh, next_tsh;
   logic       hold_full, next_hold_full;
   logic [3:0] tovs, next_tovs;
   logic [2:0] tbit, next_tbit;
   logic       next_txd;
   logic       tx_irq, next_tx_irq;
   logic       tx_sw_clr, next_tx_sw_clr;
   logic       stop_gen, load;

   // Shifter, hold register and the transmit interrupt level
   always_comb begin
      next_tx_st     = tx_st;
      next_hold      = hold;
      next_hold_full = hold_full;
      next_tsh       = tsh;
      next_tovs      = tovs;
      next_tbit      = tbit;
      next_txd       = txd_o;
      next_tx_irq    = tx_irq;
      next_tx_sw_clr = tx_sw_clr;
      stop_gen       = 1'b0;
      load           = 1'b0;
      if (tick && tx_st != uit_pkg::TX_IDLE) begin
         next_tovs = tovs + 4'h1;
      end
      case (tx_st)
         uit_pkg::TX_IDLE: begin
            next_txd = 1'b1;
            if (ctrl[`UIT_CTRL_TXEN] && hold_full && tick) begin
               load       = 1'b1;
               next_tx_st = uit_pkg::TX_START;
               next_tovs  = 4'h0;
               next_txd   = 1'b0;
            end
         end
         uit_pkg::TX_START: begin
            if (tick && tovs == `UIT_OVS) begin
               next_tx_st = uit_pkg::TX_DATA;
               next_tbit  = 3'h0;
               next_txd   = tsh[0];
            end
         end
         uit_pkg::TX_DATA: begin
            if (tick && tovs == `UIT_OVS) begin
               next_tsh  = {1'b1, tsh[7:1]};
               next_txd  = tsh[1];
               next_tbit = tbit + 3'h1;
               if (tbit == 3'h7) begin
                  next_tx_st = uit_pkg::TX_STOP;
                  next_txd   = 1'b1;
                  stop_gen   = 1'b1;
               end
            end
         end
         default: begin
            // Next frame chains straight on if the buffer is already full
            if (tick && tovs == `UIT_OVS) begin
               next_tx_st = uit_pkg::TX_IDLE;
               if (ctrl[`UIT_CTRL_TXEN] && hold_full) begin
                  load       = 1'b1;
                  next_tx_st = uit_pkg::TX_START;
                  next_txd   = 1'b0;
               end
            end
         end
      endcase
      if (load) begin
         next_tsh       = hold;
         next_hold_full = 1'b0;
         next_tx_irq    = 1'b1;
      end
      if (wr_data) begin
         next_hold      = wdata_i[7:0];
         next_hold_full = 1'b1;
         next_tx_irq    = 1'b0;
         // Write at stop generation after a software clear is swallowed
         if (tx_sw_clr && stop_gen) begin
            next_tx_sw_clr = 1'b0;
         end
      end
      if (stop_gen && !tx_sw_clr && !hold_full && !wr_data) begin
         next_tx_irq = 1'b1;
      end
      if (wr_clr && wdata_i[`UIT_IRQ_TX]) begin
         next_tx_irq    = 1'b0;
         next_tx_sw_clr = (tx_st != uit_pkg::TX_IDLE);
      end else if (tx_st == uit_pkg::TX_IDLE) begin
         next_tx_sw_clr = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_st     <= uit_pkg::TX_IDLE;
         hold      <= 8'h00;
         hold_full <= 1'b0;
         tsh       <= 8'h00;
         tovs      <= 4'h0;
         tbit      <= 3'h0;
         txd_o     <= 1'b1;
         tx_irq    <= 1'b0;
         tx_sw_clr <= 1'b0;
      end else begin
         tx_st     <= next_tx_st;
         hold      <= next_hold;
         hold_full <= next_hold_full;
         tsh       <= next_tsh;
         tovs      <= next_tovs;
         tbit      <= next_tbit;
         txd_o     <= next_txd;
         tx_irq    <= next_tx_irq;
         tx_sw_clr <= next_tx_sw_clr;
      end
   end

   // ************************************************************
   // Receiver and receive FIFO
   // ************************************************************
   logic rx_done, rx_pe, rx_fe, rx_brk;
   uit_pkg::uit_byte_t rx_data;

   uit_rx u_rx (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .tick_i     (tick),
      .en_i       (ctrl[`UIT_CTRL_RXEN]),
      .par_en_i   (ctrl[`UIT_CTRL_PAREN]),
      .par_odd_i  (ctrl[`UIT_CTRL_PARODD]),
      .rxd_i      (rx_line),
      .done_o     (rx_done),
      .data_o     (rx_data),
      .par_err_o  (rx_pe),
      .frm_err_o  (rx_fe),
      .brk_o      (rx_brk)
   );

   uit_pkg::uit_byte_t mem [8];
   logic [2:0] wp, rp, next_wp, next_rp;
   logic [3:0] cnt, next_cnt, depth;
   logic       push, pop, full, ovr_ev, rx_ev;
   logic [8:0] to_cnt, next_to_cnt;
   logic [3:0] to_ovs, next_to_ovs;
   logic       to_ev;

   // Depth is one in single-byte mode
   always_comb begin
      depth  = ctrl[`UIT_CTRL_FIFOEN] ? `UIT_FIFO_DEPTH : 4'h1;
      full   = (cnt == depth);
      ovr_ev = rx_done && full;
      push   = rx_done && !full;
      pop    = rd_data && (cnt != 4'h0);
      next_wp  = push ? wp + 3'h1 : wp;
      next_rp  = pop  ? rp + 3'h1 : rp;
      next_cnt = cnt + {3'h0, push} - {3'h0, pop};
      if (ctrl[`UIT_CTRL_FIFOEN]) begin
         rx_ev = push && (next_cnt == {1'b0, level});
      end else begin
         rx_ev = push;
      end
      // Timeout counts whole transfer-clock periods of idle line with data held
      next_to_ovs = to_ovs;
      next_to_cnt = to_cnt;
      to_ev       = 1'b0;
      if (cnt == 4'h0 || rx_done || pop || !rx_line) begin
         next_to_ovs = 4'h0;
         next_to_cnt = 9'd0;
      end else if (tick && to_cnt != `UIT_TIMEOUT_BITS) begin
         next_to_ovs = to_ovs + 4'h1;
         if (to_ovs == `UIT_OVS) begin
            next_to_cnt = to_cnt + 9'd1;
            to_ev = (to_cnt == `UIT_TIMEOUT_BITS - 9'd1);
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wp     <= 3'h0;
         rp     <= 3'h0;
         cnt    <= 4'h0;
         to_cnt <= 9'd0;
         to_ovs <= 4'h0;
      end else begin
         wp     <= next_wp;
         rp     <= next_rp;
         cnt    <= next_cnt;
         to_cnt <= next_to_cnt;
         to_ovs <= next_to_ovs;
      end
   end

   // Storage carries no reset; only the pointers define its content
   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem[wp] <= rx_data;
      end
   end

   // ************************************************************
   // Sticky status, interrupt and read port
   // ************************************************************
   logic [6:0] stat, next_stat, ev;

   // Set beats a simultaneous clear; the transmit bit follows its level
   always_comb begin
      ev = {ovr_ev, rx_brk, rx_pe, rx_fe, to_ev, 1'b0, rx_ev};
      next_stat = (stat & ~(wr_clr ? wdata_i[6:0] : 7'h00)) | ev;
      next_stat[`UIT_IRQ_TX] = next_tx_irq;
   end

   logic [31:0] next_rdata;

   // Unmapped offsets read as zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (rd_data) begin
         next_rdata = {24'h00_0000, mem[rp]};
      end else if (rd_i && hit(addr_i, {1'b0, `UIT_OFS_CTRL})) begin
         next_rdata = {27'h000_0000, ctrl};
      end else if (rd_i && hit(addr_i, {1'b0, `UIT_OFS_FLAG})) begin
         next_rdata = {29'h0000_0000, cnt == 4'h0, hold_full, tx_st != uit_pkg::TX_IDLE};
      end else if (rd_i && hit(addr_i, {1'b0, `UIT_OFS_LEVEL})) begin
         next_rdata = {29'h0000_0000, level};
      end else if (rd_i && hit(addr_i, `UIT_OFS_STATUS)) begin
         next_rdata = {25'h000_0000, stat};
      end else if (rd_i && hit(addr_i, `UIT_OFS_ENABLE)) begin
         next_rdata = {25'h000_0000, irq_en};
      end else if (rd_i && hit(addr_i, `UIT_OFS_BAUD)) begin
         next_rdata = {24'h00_0000, baud};
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         stat    <= 7'h00;
         rdata_o <= 32'h0000_0000;
      end else begin
         stat    <= next_stat;
         rdata_o <= next_rdata;
      end
   end

   assign irq_o = |(stat & irq_en);
endmodule : uit_top

// ### dv/uit_top_sva.sv
/* Port-level checker for uit_top.
   Assumes one clock, async high reset, enable register at 0x14. */
module uit_top_sva (
   input wire logic        core_clk_i,
   input wire logic        sys_rst_i,
   input wire logic [4:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic        rxd_i,
   input wire logic        txd_o,
   input wire logic        irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Shadow of the enable register
   // ****************************************
   logic [6:0] en_q;
   logic       en_ok;
   logic       wrote;
   // Enable reset value is not trusted, so gate on a first write
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         en_q  <= 7'h00;
         en_ok <= 1'b0;
         wrote <= 1'b0;
      end else begin
         if (wr_i && addr_i == 5'h14) begin
            en_q  <= wdata_i[6:0];
            en_ok <= 1'b1;
         end
         if (wr_i && addr_i == 5'h00) wrote <= 1'b1;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data not zero outside answer cycle");
   a_en_gate: assert property (en_ok && en_q == 7'h00 |-> !irq_o)
      else $error("interrupt with nothing enabled");
   a_write_clears: assert property (wr_i && addr_i == 5'h00 && en_ok && en_q == 7'h02 |=> !irq_o)
      else $error("buffer write left tx interrupt set");
   a_sw_clear: assert property (wr_i && addr_i == 5'h18 && wdata_i[1] && en_ok && en_q == 7'h02 |=> !irq_o)
      else $error("clear bit left tx interrupt set");
   a_busy_start: assert property (rd_i && addr_i == 5'h08 && !txd_o |=> rdata_o[0])
      else $error("busy low while line driven low");
   a_irq_status: assert property (rd_i && addr_i == 5'h10 && en_ok |=>
      ((|(rdata_o[6:0] & en_q)) == $past(irq_o)))
      else $error("interrupt disagrees with status");
   a_start_len: assert property ($fell(txd_o) |=> !txd_o [*8])
      else $error("start bit too short");
   a_tx_quiet: assert property (!wrote |-> txd_o)
      else $error("line active before any write");
endmodule : uit_top_sva
bind uit_top uit_top_sva u_sva (.core_clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rxd_i,
   .txd_o, .irq_o);

// ### dv/uit_remote.sv
/* Remote serial device: sends frames, captures bytes from txd.
   Assumes 8 data bits LSB first and BIT_CLKS clocks per bit. */
module uit_remote #(
   parameter int BIT_CLKS = 16
) (
   input  wire logic core_clk_i,
   input  wire logic txd_i,
   output logic      rxd_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Transmit and capture
   // ****************************************
   uit_pkg::uit_byte_t rx_q[$];
   uit_pkg::uit_byte_t cap;
   initial rxd_o = 1'b1;
   task automatic bit_out(input logic b);
      rxd_o <= b;
      repeat (BIT_CLKS) @(posedge core_clk_i);
   endtask : bit_out
   // Mode 1 even parity, mode 2 wrong parity; stp low forces a bad stop
   task automatic send(input uit_pkg::uit_byte_t d, input logic [1:0] md, input logic stp);
      bit_out(1'b0);
      for (int i = 0; i < 8; i++) bit_out(d[i]);
      if (md != 2'h0) bit_out(^d ^ md[1]);
      bit_out(stp);
      bit_out(1'b1); // Line idles high between frames
   endtask : send
   // Sample mid-bit so jitter of a cycle cannot flip a bit
   always begin
      @(negedge txd_i);
      repeat (BIT_CLKS * 3 / 2) @(posedge core_clk_i);
      for (int i = 0; i < 8; i++) begin
         cap[i] = txd_i;
         repeat (BIT_CLKS) @(posedge core_clk_i);
      end
      rx_q.push_back(cap);
   end
endmodule : uit_remote

// ### dv/tb_top.sv
/* Self-checking bench for uit_top with a remote serial partner.
   Assumes divisor 0 gives 16 clocks per bit. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk_i = 1'b0;
   logic        sys_rst_i  = 1'b1;
   logic [4:0]  addr_i     = 5'h00;
   logic [31:0] wdata_i    = 32'h0;
   logic        wr_i       = 1'b0;
   logic        rd_i       = 1'b0;
   logic [31:0] rdata_o;
   logic        rxd_i;
   logic        txd_o;
   logic        irq_o;
   int          mismatches = 0;
   int          total_checks = 0;
   int          seed = 52478;
   uit_pkg::uit_byte_t b[2];
   logic [31:0] v;
   // Last error case runs odd parity against an even-parity frame
   logic [1:0]  md[4]  = '{2'h2, 2'h0, 2'h0, 2'h1};
   logic [31:0] ctl[4] = '{32'hB, 32'h3, 32'h3, 32'h1B};
   logic [31:0] ex[4]  = '{32'h10, 32'h08, 32'h28, 32'h10};
   always #10 core_clk_i = ~core_clk_i;
   uit_top u_dut (.core_clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rxd_i, .txd_o, .irq_o);
   uit_remote u_rem (.core_clk_i, .txd_i(txd_o), .rxd_o(rxd_i));
   // ****************************************
   // Bus tasks and checks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // An edge passes after each strobe so no signal is set twice at once
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
      @(posedge core_clk_i);
   endtask : rd
   task automatic wait_irq();
      for (int n = 0; n < 400 && irq_o !== 1'b1; n++) @(posedge core_clk_i);
   endtask : wait_irq
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (20000) @(posedge core_clk_i);
      mismatches++;
      tally_and_finish();
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (2) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge core_clk_i);
      rd(5'h1C, v);
      chk(v, 32'h1A);
      wr(5'h1C, 32'h0);
      wr(5'h04, 32'h3);
      wr(5'h14, 32'h2);
      b[0] = uit_pkg::uit_byte_t'($random(seed));
      b[1] = uit_pkg::uit_byte_t'($random(seed));
      wr(5'h00, {24'h0, b[0]});
      wait_irq();
      chk(32'(irq_o), 32'h1);
      // Continuous sending relies on the write alone to clear the interrupt
      wr(5'h00, {24'h0, b[1]});
      chk(32'(irq_o), 32'h0);
      wait_irq();
      chk(32'(irq_o), 32'h1);
      rd(5'h08, v);
      chk(v & 32'h1, 32'h1);
      repeat (40) @(posedge core_clk_i);
      wr(5'h18, 32'h2);
      chk(32'(irq_o), 32'h0);
      // Poll busy before reusing the line
      for (int n = 0; n < 100 && v[0] !== 1'b0; n++) rd(5'h08, v);
      chk(32'(irq_o), 32'h0);
      chk(32'(u_rem.rx_q.size()), 32'h2);
      for (int k = 0; k < 2; k++) chk(32'(u_rem.rx_q.pop_front()), 32'(b[k]));
      $display("tx test done");
      wr(5'h14, 32'h1);
      for (int k = 0; k < 2; k++) begin
         b[0] = uit_pkg::uit_byte_t'($random(seed));
         u_rem.send(b[0], 2'h0, 1'b1);
         wait_irq();
         rd(5'h00, v);
         chk(v & 32'hFF, 32'(b[0]));
         wr(5'h18, 32'h7F);
      end
      $display("rx test done");
      wr(5'h14, 32'h38);
      for (int k = 0; k < 4; k++) begin
         wr(5'h04, ctl[k]);
         b[0] = (k == 2) ? 8'h00 : uit_pkg::uit_byte_t'($random(seed));
         u_rem.send(b[0], md[k], (k == 0) || (k == 3));
         rd(5'h10, v);
         chk(v & ex[k], ex[k]);
         wr(5'h18, 32'h7F);
      end
      $display("error test done");
      // The first error frame is still held; empty it so the level count starts at zero
      rd(5'h00, v);
      wr(5'h04, 32'h7);
      wr(5'h0C, 32'h3);
      wr(5'h14, 32'h1);
      for (int k = 0; k < 9; k++) begin
         u_rem.send(uit_pkg::uit_byte_t'($random(seed)), 2'h0, 1'b1);
         rd(5'h10, v);
         if (k == 1) chk(v & 32'h1, 32'h0);
         if (k == 2) chk(v & 32'h1, 32'h1);
      end
      chk(v & 32'h40, 32'h40);
      wr(5'h18, 32'h7F);
      repeat (500 * 16) @(posedge core_clk_i);
      rd(5'h10, v);
      chk(v & 32'h4, 32'h0);
      repeat (20 * 16) @(posedge core_clk_i);
      rd(5'h10, v);
      chk(v & 32'h4, 32'h4);
      $display("fifo test done");
      tally_and_finish();
   end
endmodule : tb_top
